// file: verilog/sync_serial_regs.vh
/*
 * register offsets, field positions, reset values and rate codes of the
 * clocked serial transmit block.
 * assumes inclusion by bare name from the design file.
 */
`ifndef SYNC_SERIAL_REGS_VH
`define SYNC_SERIAL_REGS_VH

// ****************************************
// byte addresses on the avalon word bus
// ****************************************
`define ADDR_CONTROL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_RXBUF 4'h8
`define ADDR_TXBUF 4'hC

// ****************************************
// control register fields
// ****************************************
`define CTL_START 7
`define CTL_FSTOP 6
`define CTL_MODE_HI 5
`define CTL_MODE_LO 4
`define CTL_DIR 3
`define CTL_SCK_HI 2
`define CTL_SCK_LO 0
`define CTL_RESET 8'h00

// ****************************************
// status register fields
// ****************************************
`define ST_BUSY 7
`define ST_CNT 6
`define ST_TXE 5
`define ST_RXF 4
`define ST_TRANSMIT_ERROR_FLAG 3
`define ST_RXERR 2

// ****************************************
// codes
// ****************************************
`define MODE_TX 2'h0
`define MODE_RX 2'h1
`define MODE_TXRX 2'h2
`define SCK_EXT 3'h7
`define SCK_SLOWCODE 3'h0

// ****************************************
// rates: clock frequencies in hz, and half periods in core clocks
// ****************************************
`define FS_HZ 32768
`define CORE_HZ 50000000
// fs/2^4 half period: core/(fs/16)/2 rounded down
`define HALF_FS16 16'h2FAF
`define HALF_FC12 16'h0800
`endif

// file: verilog/sync_serial_clock_transmit.v
/*
 * clocked 8-bit synchronous serial interface, transmit path, with an
 * avalon-mm register slave, clock generation/selection and auto wait.
 * assumes core_clk is the fc clock; the timebase divider bit and the
 * low-power mode flag come from elsewhere in the chip as plain inputs.
 */
// The register offsets and register access over Avalon-MM are this design's own decisions.
// Function
// [RULE_01] internal clock: drive generated clock on pin, idle high outside transfers
// [RULE_02] codes 001..110 divide fc by 2^8..2^3; code 000 fc/2^12 or fs/2^4
// [RULE_03] internal clock stops automatically until software refills buffer
// [RULE_04] after wait release clock resumes within one serial clock period
// [RULE_05] code 111 uses the clock pin input as shift clock
// [RULE_06] external clock high and low phases last at least four fc periods
// [RULE_07] transmit changes on falling edge, receive samples on rising edge
// [RULE_08] one bit-order bit for both directions: 0 bit7 first, 1 bit0 first
// [RULE_09] software changes order and clock only while busy flag is 0
// [RULE_10] mode code 00 selects transmit-only operation
// [RULE_11] each transmit buffer write clears the buffer-empty flag; here a write in the cycle the flag sets is dropped and the flag stays set
// [RULE_12] busy flag sets with the next falling clock edge after start
// [RULE_13] byte shifts out one bit per falling edge in chosen order
// [RULE_14] count monitor high from first to eighth falling edge of a byte
// [RULE_15] empty flag sets at rising edge after load; interrupt next falling edge
// [RULE_16] internal clock: start waits until a byte has been written
// [RULE_17] internal clock: load within one period, then output clock
// [RULE_18] external clock: load buffer on first received falling edge
// [RULE_19] internal clock: no next byte parks clock high until buffer write
// [RULE_20] byte written before current finishes follows without a gap
// [RULE_21] external clock: software writes next byte before its shifting begins
// [RULE_22] external shift with empty buffer sets error flag then interrupt
// [RULE_23] mode 01 receive, 10 transmit/receive, 11 reserved
// [RULE_24] error flag cleared only by writing 0, not by stopping
// [RULE_25] forced stop halts, clears start, status and buffers, self-clears
// [RULE_26] external clock synchronised and edge-detected in core domain
`include "sync_serial_regs.vh"

module sync_serial_clock_transmit (
    input wire core_clk,
    input wire rst,
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output wire [31:0] readdata,
    output wire waitrequest,
    input wire timebase_divider_bit,
    input wire low_power_mode,
    input wire serialClockIn,
    output wire serialClockOut,
    output wire serialClockOe,
    output wire serialDataOut,
    input wire serialDataIn,
    output wire serialInterruptRequest
);

    localparam ST_IDLE = 2'h0;
    localparam ST_SHIFT = 2'h1;
    localparam ST_WAIT = 2'h2;

    // ****************************************
    // registers
    // ****************************************
    reg startBit_ff;
    reg [1:0] transferModeField_ff;
    reg bitOrderControl_ff;
    reg [2:0] clockSelect_ff;
    reg transferInProgress_ff;
    reg clockCountMonitor_ff;
    reg txEmpty_ff;
    reg rxFull_ff;
    reg txError_ff;
    reg [7:0] txBuf_ff;
    reg [7:0] rxBuf_ff;
    reg [7:0] shift_ff;
    reg [3:0] bitCnt_ff;
    reg [1:0] state_ff;
    reg loaded_ff;
    reg pendIrq_ff;
    reg irq_ff;
    reg sckOut_ff;
    reg dataOut_ff;
    reg [15:0] divCnt_ff;
    reg [2:0] sckSync_ff;
    reg ackDone_ff;
    reg [31:0] readdata_ff;

    // ****************************************
    // helpers
    // ****************************************
    function [15:0] halfPeriod;
        input [2:0] code;
        input tbBit;
        begin
            case (code)
                3'h0: halfPeriod = tbBit ? `HALF_FS16 : `HALF_FC12; // [RULE_02]
                3'h1: halfPeriod = 16'h0080;
                3'h2: halfPeriod = 16'h0040;
                3'h3: halfPeriod = 16'h0020;
                3'h4: halfPeriod = 16'h0010;
                3'h5: halfPeriod = 16'h0008;
                3'h6: halfPeriod = 16'h0004;
                default: halfPeriod = 16'h0004;
            endcase
        end
    endfunction

    // next bit to present, msb or lsb first
    function nextBit;
        input [7:0] val;
        input lsbFirst;
        begin
            nextBit = lsbFirst ? val[0] : val[7]; // [RULE_08]
        end
    endfunction

    // advance the shift register by one bit in the chosen order
    function [7:0] shiftOn;
        input [7:0] val;
        input lsbFirst;
        begin
            shiftOn = lsbFirst ? {1'b0, val[7:1]} : {val[6:0], 1'b0}; // [RULE_08]
        end
    endfunction

    wire extClk = (clockSelect_ff == `SCK_EXT);
    // slow modes only run code 000 from fs/16
    wire rateValid = !low_power_mode || (clockSelect_ff == `SCK_SLOWCODE);
    wire tbSel = timebase_divider_bit || low_power_mode;
    wire [15:0] halfLen = halfPeriod(clockSelect_ff, tbSel);
    wire txMode = (transferModeField_ff == `MODE_TX) ||
                  (transferModeField_ff == `MODE_TXRX); // [RULE_10] [RULE_23]
    wire rxMode = (transferModeField_ff == `MODE_RX) ||
                  (transferModeField_ff == `MODE_TXRX); // [RULE_23]

    // ****************************************
    // bus decode
    // ****************************************
    // writes land at the edge that sees waitrequest low, as the master expects
    wire busWr = write && ackDone_ff;
    wire busRd = read && !ackDone_ff;
    wire wrCtl = busWr && (address == `ADDR_CONTROL);
    wire wrSt = busWr && (address == `ADDR_STATUS);
    wire wrTx = busWr && (address == `ADDR_TXBUF);
    wire rdRx = busRd && (address == `ADDR_RXBUF);
    wire forceStop = wrCtl && writedata[`CTL_FSTOP];
    assign waitrequest = (read || write) && !ackDone_ff;
    assign readdata = readdata_ff;

    // ****************************************
    // external clock: three flops, agreement of last two
    // ****************************************
    reg sckLevel_ff;
    wire sckAgree = (sckSync_ff[1] == sckSync_ff[2]);
    wire extFall = extClk && sckAgree && sckLevel_ff && !sckSync_ff[2]; // [RULE_26]
    wire extRise = extClk && sckAgree && !sckLevel_ff && sckSync_ff[2]; // [RULE_26]

    // ****************************************
    // internal clock generator: pulse per half period
    // ****************************************
    wire halfTick = (divCnt_ff >= halfLen - 16'h0001);
    // park at the would-be first falling edge of a byte with nothing to send,
    // so the eighth bit keeps its full low phase before the clock stops
    wire intStall = (bitCnt_ff == 4'h8) && (!startBit_ff || (txMode && txEmpty_ff));
    wire intFall = !extClk && halfTick && sckOut_ff && (state_ff == ST_SHIFT) && !intStall;
    wire intRise = !extClk && halfTick && !sckOut_ff;
    wire fallEdge = extClk ? extFall : intFall; // [RULE_07]
    wire riseEdge = extClk ? extRise : intRise; // [RULE_07]
    wire lastFall = fallEdge && (bitCnt_ff == 4'h7);

    reg [7:0] nxt_shift;
    reg [3:0] nxt_bitCnt;
    reg [1:0] nxt_state;
    always @* begin
        nxt_shift = shift_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                // internal start needs a written byte [RULE_16] [RULE_17]
                if (startBit_ff && rateValid && (extClk || !txEmpty_ff || !txMode)) begin
                    nxt_state = extClk ? ST_WAIT : ST_SHIFT;
                end
            end
            ST_WAIT: begin
                if (!startBit_ff) begin
                    nxt_state = ST_IDLE;
                end else if (!extClk && (!txEmpty_ff || !txMode)) begin
                    nxt_state = ST_SHIFT; // [RULE_03] [RULE_19]
                end else if (extClk && extFall) begin
                    nxt_state = ST_SHIFT; // [RULE_18]
                end
            end
            ST_SHIFT: begin
                // auto wait: no byte ready, or start cleared, at the byte boundary
                if (!extClk && halfTick && sckOut_ff && intStall) begin
                    nxt_state = ST_WAIT; // [RULE_03] [RULE_19]
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // ****************************************
    // shift engine
    // ****************************************
    wire firstFall = fallEdge && (bitCnt_ff == 4'h0 || bitCnt_ff == 4'h8) &&
                     (state_ff == ST_SHIFT || (extClk && state_ff == ST_WAIT));
    wire startByte = firstFall && startBit_ff;
    always @(posedge core_clk) begin
        if (rst || forceStop) begin // [RULE_25]
            state_ff <= ST_IDLE;
            shift_ff <= 8'h00;
            bitCnt_ff <= 4'h0;
            loaded_ff <= 1'b0;
            sckOut_ff <= 1'b1;
            divCnt_ff <= 16'h0000;
            dataOut_ff <= 1'b1;
            transferInProgress_ff <= 1'b0;
            clockCountMonitor_ff <= 1'b0;
            pendIrq_ff <= 1'b0;
            irq_ff <= 1'b0;
            rxBuf_ff <= 8'h00;
            rxFull_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            irq_ff <= 1'b0;
            if (state_ff == ST_SHIFT && !extClk) begin
                divCnt_ff <= halfTick ? 16'h0000 : divCnt_ff + 16'h0001;
                if (intFall || intRise) begin
                    sckOut_ff <= !sckOut_ff; // [RULE_01]
                end
            end else begin
                // resume within one period once the wait clears [RULE_04]
                divCnt_ff <= 16'h0000;
                sckOut_ff <= 1'b1; // [RULE_01] [RULE_19]
            end
            if (startByte) begin
                transferInProgress_ff <= 1'b1; // [RULE_12]
                clockCountMonitor_ff <= 1'b1; // [RULE_14]
                bitCnt_ff <= 4'h1;
                if (txMode && !txEmpty_ff) begin
                    // load buffer and present first bit [RULE_13] [RULE_20]
                    shift_ff <= shiftOn(txBuf_ff, bitOrderControl_ff);
                    dataOut_ff <= nextBit(txBuf_ff, bitOrderControl_ff);
                    loaded_ff <= 1'b1;
                end else if (txMode) begin
                    // underrun: ones keep the line high for the whole byte
                    dataOut_ff <= 1'b1; // [RULE_22]
                    shift_ff <= 8'hFF;
                end
                if (pendIrq_ff) begin
                    irq_ff <= 1'b1; // [RULE_15]
                    pendIrq_ff <= 1'b0;
                end
            end else if (fallEdge && bitCnt_ff != 4'h0 && bitCnt_ff != 4'h8) begin
                dataOut_ff <= nextBit(shift_ff, bitOrderControl_ff); // [RULE_13]
                shift_ff <= shiftOn(shift_ff, bitOrderControl_ff);
                bitCnt_ff <= bitCnt_ff + 4'h1;
                if (lastFall) begin
                    clockCountMonitor_ff <= 1'b0; // [RULE_14]
                end
                if (pendIrq_ff) begin
                    irq_ff <= 1'b1; // [RULE_15]
                    pendIrq_ff <= 1'b0;
                end
            end else if (fallEdge && !startBit_ff && bitCnt_ff == 4'h8) begin
                transferInProgress_ff <= 1'b0;
            end
            if (riseEdge && loaded_ff) begin
                loaded_ff <= 1'b0;
                pendIrq_ff <= 1'b1; // [RULE_15]
            end
            if (state_ff == ST_WAIT && !startBit_ff && !extClk) begin
                transferInProgress_ff <= 1'b0;
                dataOut_ff <= 1'b1;
            end
            if (riseEdge && rxMode && clockCountMonitor_ff) begin
                rxBuf_ff <= bitOrderControl_ff ? {serialDataIn, rxBuf_ff[7:1]}
                                               : {rxBuf_ff[6:0], serialDataIn};
            end
            // a receive buffer read frees it
            if (rdRx) begin
                rxFull_ff <= 1'b0;
            end
            // error flag rises now; the interrupt waits for the next falling edge
            if (startByte && txMode && txEmpty_ff && extClk) begin
                pendIrq_ff <= 1'b1; // [RULE_22]
            end
        end
    end

    // ****************************************
    // control, status and buffers
    // ****************************************
    wire setTxEmpty = riseEdge && loaded_ff;
    wire setTxErr = startByte && txMode && txEmpty_ff && extClk; // [RULE_22]
    always @(posedge core_clk) begin
        if (rst || forceStop) begin // [RULE_25]
            startBit_ff <= 1'b0;
            txEmpty_ff <= 1'b1;
            txError_ff <= 1'b0;
            txBuf_ff <= 8'h00;
        end else begin
            if (wrCtl) begin
                startBit_ff <= writedata[`CTL_START];
            end
            // set wins over a same-cycle write
            if (setTxEmpty) begin
                txEmpty_ff <= 1'b1; // [RULE_15]
            end else if (wrTx) begin
                txEmpty_ff <= 1'b0; // [RULE_11]
            end
            if (wrTx && txEmpty_ff) begin
                txBuf_ff <= writedata[7:0];
            end
            if (setTxErr) begin
                txError_ff <= 1'b1;
            end else if (wrSt && !writedata[`ST_TRANSMIT_ERROR_FLAG]) begin
                txError_ff <= 1'b0; // [RULE_24]
            end
        end
    end

    // mode, order and clock: software keeps them still while busy
    always @(posedge core_clk) begin
        if (rst) begin
            transferModeField_ff <= 2'h0;
            bitOrderControl_ff <= 1'b0;
            clockSelect_ff <= 3'h0;
        end else if (wrCtl) begin // [RULE_09]
            transferModeField_ff <= writedata[`CTL_MODE_HI:`CTL_MODE_LO];
            bitOrderControl_ff <= writedata[`CTL_DIR];
            clockSelect_ff <= writedata[`CTL_SCK_HI:`CTL_SCK_LO]; // [RULE_05]
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            sckSync_ff <= 3'h7;
            sckLevel_ff <= 1'b1;
        end else begin
            sckSync_ff <= {sckSync_ff[1:0], serialClockIn}; // [RULE_26]
            if (sckAgree) begin
                sckLevel_ff <= sckSync_ff[2];
            end
        end
    end

    // one-wait answer: every access is acknowledged on its second edge
    always @(posedge core_clk) begin
        if (rst) begin
            ackDone_ff <= 1'b0;
            readdata_ff <= 32'h00000000;
        end else begin
            ackDone_ff <= (read || write) && !ackDone_ff;
            if (busRd) begin
                case (address)
                    `ADDR_CONTROL: readdata_ff <= {24'h000000, startBit_ff, 1'b0,
                        transferModeField_ff, bitOrderControl_ff, clockSelect_ff};
                    `ADDR_STATUS: readdata_ff <= {24'h000000, transferInProgress_ff,
                        clockCountMonitor_ff, txEmpty_ff, rxFull_ff, txError_ff, 3'h0};
                    `ADDR_RXBUF: readdata_ff <= {24'h000000, rxBuf_ff};
                    default: readdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    assign serialClockOut = sckOut_ff;
    assign serialClockOe = !extClk; // [RULE_01]
    assign serialDataOut = dataOut_ff;
    assign serialInterruptRequest = irq_ff;
endmodule

// file: tb/sync_serial_props.sv
/*
 * port assertions for the clocked serial transmit block.
 * assumes a bind from tb and one core_clk domain with synchronous rst.
 */
module sync_serial_props (
    input wire core_clk,
    input wire rst,
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire waitrequest,
    input wire serialClockOut,
    input wire serialClockOe,
    input wire serialDataOut,
    input wire serialInterruptRequest
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ****************************************
    // clock select as last written
    // ****************************************
    logic [2:0] sckCode_ff;
    always @(posedge core_clk) begin
        if (rst) begin
            sckCode_ff <= 3'h0;
        end else if (write && !waitrequest && address == 4'h0) begin
            sckCode_ff <= writedata[2:0];
        end
    end
    sequence heldRequest;
        (read || write) && waitrequest;
    endsequence
    sequence lowPhaseFast;
        !serialClockOut [*3] ##1 serialClockOut;
    endsequence
    chk_oe_follows_code: assert property ($stable(sckCode_ff) ##1 $stable(sckCode_ff)
        |-> serialClockOe == (sckCode_ff != 3'h7)) else $error("clock enable wrong for code");
    chk_reset_idle_lines: assert property ($past(rst)
        |-> serialClockOut && serialDataOut && !serialInterruptRequest) else $error("idle level");
    chk_irq_one_cycle: assert property (serialInterruptRequest |=> !serialInterruptRequest)
        else $error("interrupt longer than one cycle");
    chk_one_wait_state: assert property (heldRequest |=> !waitrequest)
        else $error("more than one wait state");
    chk_data_hold_rise: assert property (serialClockOe && $rose(serialClockOut)
        |-> $stable(serialDataOut)) else $error("data moved on sampling edge");
    chk_fast_low_phase: assert property (sckCode_ff == 3'h6 && $fell(serialClockOut)
        |=> lowPhaseFast) else $error("low phase not four cycles");
    chk_irq_in_low: assert property (serialInterruptRequest && serialClockOe
        |-> !serialClockOut) else $error("interrupt away from falling edge");
    chk_fall_needs_oe: assert property ($fell(serialClockOut) |-> serialClockOe)
        else $error("clock driven under external select");
endmodule

// file: tb/serial_peer.sv
/*
 * far-side serial peer: samples the data line on rising clock edges and
 * can supply an external clock. assumes tb resolves the clock wire.
 */
module serial_peer (
    input wire core_clk,
    input wire sckLine,
    input wire serialDataOut,
    output logic extClk,
    output logic serialDataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prevLine = 1'b1;
    logic [15:0] shiftData;
    int bitCount;
    int gap;
    int maxGap;
    task automatic clear();
        bitCount = 0;
        gap = 0;
        maxGap = 0;
        shiftData = 16'h0000;
    endtask
    // phases of six core cycles keep above the four-cycle minimum
    task automatic ext_clock(input int n);
        repeat (n) begin
            @(posedge core_clk);
            extClk <= 1'b0;
            repeat (6) @(posedge core_clk);
            extClk <= 1'b1;
            repeat (5) @(posedge core_clk);
        end
    endtask
    initial begin
        extClk = 1'b1;
        serialDataIn = 1'b0;
        clear();
    end
    // receive is unused here, so the line keeps moving to expose stale use
    always @(posedge core_clk) begin
        serialDataIn <= ~serialDataIn;
        prevLine <= sckLine;
        gap <= gap + 1;
        if (prevLine && !sckLine) begin
            if (bitCount > 0 && bitCount < 16 && gap > maxGap) maxGap <= gap;
            gap <= 1;
        end
        if (!prevLine && sckLine) begin
            bitCount <= bitCount + 1;
            shiftData <= {shiftData[14:0], serialDataOut};
        end
    end
endmodule

// file: tb/tb.sv
/*
 * self-checking bench for the serial transmit block.
 * assumes nothing of the slave's latency; every wait is bounded.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic tbDiv = 1'b0;
    logic lowPower = 1'b0;
    logic [31:0] rd;
    wire [31:0] readdata;
    wire waitrequest, serialClockOut, serialClockOe, serialDataOut, serialInterruptRequest;
    wire extClk, serialDataIn;
    wire sckLine = serialClockOe ? serialClockOut : extClk;
    int errCount = 0;
    int testsRun = 0;
    always #10 core_clk = ~core_clk;
    sync_serial_clock_transmit dut (.core_clk(core_clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .timebase_divider_bit(tbDiv), .low_power_mode(lowPower),
        .serialClockIn(sckLine), .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
        .serialDataOut(serialDataOut), .serialDataIn(serialDataIn),
        .serialInterruptRequest(serialInterruptRequest));
    serial_peer peer (.core_clk(core_clk), .sckLine(sckLine), .serialDataOut(serialDataOut),
        .extClk(extClk), .serialDataIn(serialDataIn));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errCount++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge core_clk);
            n++;
            if (n > 50) begin
                errCount++;
                completeRun();
            end
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic waitIrq();
        int n;
        for (n = 0; n < 400 && serialInterruptRequest !== 1'b1; n++) @(negedge core_clk);
        if (n == 400) begin
            errCount++;
            completeRun();
        end
    endtask
    task automatic waitBits(input int k, input int lim);
        int n;
        for (n = 0; n < lim && peer.bitCount < k; n++) @(negedge core_clk);
        check(n < lim, 1'b1);
        if (n == lim) completeRun();
    endtask
    function automatic logic [7:0] rev8(input logic [7:0] d);
        for (int i = 0; i < 8; i++) rev8[i] = d[7 - i];
    endfunction
    // ****************************************
    // scenarios
    // ****************************************
    task automatic resetAndModes();
        bus(0, 4'h4, 0);
        check(rd & 32'hFFFFFFFC, 32'h00000020);
        bus(0, 4'h8, 0);
        check(rd, 32'h00000000);
        for (int m = 0; m < 3; m++) begin
            bus(1, 4'h0, m << 4 | 32'h6);
            bus(0, 4'h0, 0);
            check(rd & 32'h30, m << 4);
        end
    endtask
    task automatic runInternal(input logic dirBit);
        logic [7:0] ctl;
        ctl = {4'h8, dirBit, 3'h6};
        peer.clear();
        bus(1, 4'h0, {24'h0, ctl});
        repeat (40) @(posedge core_clk);
        check(peer.bitCount, 0);
        check(serialClockOut, 1'b1);
        bus(1, 4'hC, 32'hB4);
        waitIrq();
        bus(0, 4'h4, 0);
        check(rd & 32'hF8, 32'hE0);
        bus(1, 4'hC, 32'h1D);
        bus(0, 4'h4, 0);
        check(rd & 32'h20, 32'h00);
        waitBits(16, 600);
        repeat (60) @(posedge core_clk);
        check(peer.bitCount, 16);
        check(serialClockOut, 1'b1);
        check(peer.maxGap, 8);
        check(peer.shiftData, dirBit ? {rev8(8'hB4), rev8(8'h1D)} : 16'hB41D);
        bus(1, 4'hC, 32'h5A);
        waitBits(17, 20);
        bus(1, 4'h0, {24'h0, 4'h4, dirBit, 3'h6});
        repeat (20) @(posedge core_clk);
        check(serialClockOut, 1'b1);
        bus(0, 4'h4, 0);
        check(rd & 32'hF8, 32'h20);
        bus(0, 4'h0, 0);
        check(rd & 32'hC0, 32'h00);
    endtask
    task automatic runExternal();
        peer.clear();
        bus(1, 4'h0, 32'h07);
        bus(1, 4'hC, 32'h96);
        bus(1, 4'h0, 32'h87);
        check(serialClockOe, 1'b0);
        peer.ext_clock(8);
        check(peer.shiftData[7:0], 8'h96);
        fork
            peer.ext_clock(2);
            waitIrq();
        join
        check(serialDataOut, 1'b1);
        bus(0, 4'h4, 0);
        check(rd & 32'h08, 32'h08);
        bus(1, 4'h0, 32'h07);
        bus(1, 4'h4, 32'h08);
        bus(0, 4'h4, 0);
        check(rd & 32'h08, 32'h08);
        bus(1, 4'h4, 32'h00);
        bus(0, 4'h4, 0);
        check(rd & 32'h08, 32'h00);
    endtask
    task automatic slowRate();
        peer.clear();
        bus(1, 4'h0, 32'h40);
        lowPower <= 1'b1;
        bus(1, 4'hC, 32'h3C);
        bus(1, 4'h0, 32'h86);
        repeat (40) @(posedge core_clk);
        check(peer.bitCount, 0);
        bus(0, 4'h4, 0);
        check(rd & 32'h80, 32'h00);
        bus(1, 4'h0, 32'h40);
        lowPower <= 1'b0;
        tbDiv <= 1'b1;
        bus(1, 4'hC, 32'h3C);
        bus(1, 4'h0, 32'h81);
        waitBits(8, 2400);
        check(peer.maxGap, 256);
        check(peer.shiftData[7:0], 8'h3C);
        bus(1, 4'h0, 32'h40);
        tbDiv <= 1'b0;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        resetAndModes();
        runInternal(1'b0);
        runInternal(1'b1);
        runExternal();
        slowRate();
        completeRun();
    end
endmodule
bind sync_serial_clock_transmit sync_serial_props props (.core_clk(core_clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .waitrequest(waitrequest), .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
    .serialDataOut(serialDataOut), .serialInterruptRequest(serialInterruptRequest));
